// [logic/usb_out_ep_defines.vh]
// Purpose: constants for the OUT endpoint 1-3 control and status logic
// Assumes: 8-bit register port, byte offsets as listed here
// Notes:   definitions only; included by the control module
`ifndef USB_OUT_EP_DEFINES_VH
`define USB_OUT_EP_DEFINES_VH

// register offsets
`define OFS_EP_INDEX      8'h0E
`define OFS_OUT_CTRL_LOW  8'h14
`define OFS_OUT_CTRL_HIGH 8'h15
`define OFS_RX_COUNT_LOW  8'h16
`define OFS_RX_COUNT_HIGH 8'h17
`define OFS_IRQ_STATUS    8'h20
`define OFS_IRQ_ENABLE    8'h21
`define OFS_IRQ_CLEAR     8'h22

// control low byte fields
`define BIT_TOGGLE_CLEAR  7
`define BIT_STALL_SENT    6
`define BIT_STALL_REQUEST 5
`define BIT_FLUSH         4
`define BIT_DATA_ERROR    3
`define BIT_OVERRUN       2
`define BIT_FIFO_FULL     1
`define BIT_PACKET_READY  0

// control high byte fields
`define BIT_DOUBLE_BUFFER 7
`define BIT_ISO_MODE      6

// interrupt layout: data event at bit n, stall event at bit n+4, endpoint n
`define IRQ_STALL_SHIFT   4

// widths and reset values
`define COUNT_W           10
`define RST_BYTE          8'h00
`define RST_INDEX         2'h0
`define RST_COUNT         10'h000
`define RST_OCC           2'h0

`endif

// [logic/out_ep_pkt_queue.v]
// Purpose: two-slot queue of received packet lengths for one OUT endpoint
// Assumes: caller pushes only while not full
// Notes:   a pop of an empty queue is ignored
`timescale 1ns/100ps
`default_nettype none
`include "usb_out_ep_defines.vh"

module out_ep_pkt_queue (
   // clock and reset
   input  wire                   i_clock,
   input  wire                   i_rst_n,
   // queue control
   input  wire                   i_push,
   input  wire                   i_pop,
   input  wire [`COUNT_W-1:0]    i_len,
   input  wire                   i_double,
   // queue state
   output wire [`COUNT_W-1:0]    o_head_len,
   output wire [1:0]             o_occ,
   output wire                   o_full
);

   reg  [`COUNT_W-1:0] slot0_reg;
   reg  [`COUNT_W-1:0] slot1_reg;
   reg  [1:0]          occ_reg;
   wire                pop_ok;

   assign pop_ok     = i_pop && (occ_reg != 2'h0);
   assign o_head_len = slot0_reg;
   assign o_occ      = occ_reg;
   // full at two packets when double buffered, else at one
   assign o_full     = i_double ? (occ_reg == 2'h2) : (occ_reg != 2'h0);

   ////////////////////////////////////////////////////////////////////////
   // slot shifting; pop moves the second packet to the head
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         slot0_reg <= `RST_COUNT;
         slot1_reg <= `RST_COUNT;
         occ_reg   <= `RST_OCC;
      end else if (i_push && pop_ok) begin
         if (occ_reg == 2'h1) begin
            slot0_reg <= i_len;
         end else begin
            slot0_reg <= slot1_reg;
            slot1_reg <= i_len;
         end
      end else if (i_push) begin
         if (occ_reg == 2'h0) begin
            slot0_reg <= i_len;
         end else begin
            slot1_reg <= i_len;
         end
         occ_reg <= occ_reg + 2'h1;
      end else if (pop_ok) begin
         slot0_reg <= slot1_reg;
         occ_reg   <= occ_reg - 2'h1;
      end
   end

endmodule // out_ep_pkt_queue
`default_nettype wire

// [logic/usb_out_ep_ctrl.v]
// What this block does
// - writing one to toggle clear zeroes the endpoint toggle; bit reads zero
// - sending a STALL handshake sets stall sent until software clears it
// - while stall request is one, OUT transfers are answered with STALL
// - flush discards the next stored packet and clears packet ready
// - flush bit self-clears when done; one write flushes one packet only
// - iso CRC or stuff error sets data error; cleared when software clears packet ready
// - iso packet arriving with full FIFO sets overrun until software clears
// - FIFO full means two packets double buffered, otherwise one packet
// - packet ready is set when a received packet sits in the FIFO
// - received byte count is ten bits, valid only while packet ready
// - every STALL sent on the endpoint also raises an endpoint interrupt
// - with two packets stored, packet ready rises again after its clear
//
// Purpose: control and status for USB OUT endpoints 1-3 behind a byte port
// Assumes: receive engine gives one done pulse per OUT data packet
// Notes:   only packet lengths are queued; payload storage lives elsewhere
`timescale 1ns/100ps
`default_nettype none
`include "usb_out_ep_defines.vh"

module usb_out_ep_ctrl (
   // clock and reset
   input  wire                   i_clock,
   input  wire                   i_rst_n,
   // register port
   input  wire [7:0]             i_addr,
   input  wire [7:0]             i_wdata,
   input  wire                   i_wr,
   input  wire                   i_rd,
   output wire [7:0]             o_rdata,
   // packet receive side
   input  wire                   i_rx_done,
   input  wire [1:0]             i_rx_ep,
   input  wire [`COUNT_W-1:0]    i_rx_len,
   input  wire                   i_rx_toggle,
   input  wire                   i_rx_crc_err,
   // handshake answer to the host
   output wire                   o_hs_ack,
   output wire                   o_hs_nak,
   output wire                   o_hs_stall,
   // interrupt
   output wire                   o_irq
);

   ////////////////////////////////////////////////////////////////////////
   // shared registers and per-endpoint views

   reg  [1:0]            index_reg;
   reg  [7:0]            irq_stat_reg;
   reg  [7:0]            irq_en_reg;
   reg  [7:0]            rdata_reg;
   reg                   irq_reg;
   reg                   ack_reg;
   reg                   nak_reg;
   reg                   stall_reg;

   reg  [7:0]            rdata_next;
   wire [7:0]            irq_stat_next;
   wire [7:0]            irq_event;
   wire                  sel_valid;

   // per-endpoint state, index 1..3 is the endpoint number
   wire [3:1]            prdy_v;
   wire [3:1]            stall_sent_v;
   wire [3:1]            stall_req_v;
   wire [3:1]            flush_v;
   wire [3:1]            derr_v;
   wire [3:1]            ovr_v;
   wire [3:1]            full_v;
   wire [3:1]            dbl_v;
   wire [3:1]            iso_v;
   wire [3:1]            ack_v;
   wire [3:1]            nak_v;
   wire [3:1]            stall_v;
   wire [3:1]            data_ev_v;
   wire [3:1]            stall_ev_v;
   wire [`COUNT_W-1:0]   head_len [1:3];

   // index 0 selects nothing here; control writes are then dropped
   assign sel_valid = (index_reg != 2'h0);

   ////////////////////////////////////////////////////////////////////////
   // endpoint index register
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         index_reg <= `RST_INDEX;
      end else if (i_wr && (i_addr == `OFS_EP_INDEX)) begin
         index_reg <= i_wdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-endpoint control and status logic
   genvar g;
   generate
      for (g = 1; g <= 3; g = g + 1) begin : ep
         localparam [1:0] EPN = g;

         reg                 prdy_reg;
         reg                 stall_sent_reg;
         reg                 stall_req_reg;
         reg                 flush_reg;
         reg                 derr_reg;
         reg                 ovr_reg;
         reg                 toggle_reg;
         reg                 dbl_reg;
         reg                 iso_reg;

         wire                sel;
         wire                wr_low;
         wire                wr_high;
         wire                rx_here;
         wire                tog_ok;
         wire                stall_hit;
         wire                store;
         wire                ovr_set;
         wire                derr_set;
         wire                sw_clr_prdy;
         wire                flush_pop;
         wire                pop;
         wire                bulk_good;
         wire [1:0]          occ;

         assign sel     = (index_reg == EPN);
         assign wr_low  = i_wr && sel && (i_addr == `OFS_OUT_CTRL_LOW);
         assign wr_high = i_wr && sel && (i_addr == `OFS_OUT_CTRL_HIGH);
         assign rx_here = i_rx_done && (i_rx_ep == EPN);
         assign tog_ok  = (i_rx_toggle == toggle_reg);

         // stall takes priority over every other answer
         assign stall_hit = rx_here && stall_req_reg;
         // bulk packet with clean CRC that found room
         assign bulk_good = rx_here && !stall_req_reg && !iso_reg
                            && !i_rx_crc_err && !full_v[g];
         // iso keeps damaged packets; bulk drops a repeated toggle silently
         assign store   = rx_here && !stall_req_reg && !full_v[g]
                          && (iso_reg || (!i_rx_crc_err && tog_ok));
         assign ovr_set  = rx_here && !stall_req_reg && iso_reg && full_v[g];
         assign derr_set = store && iso_reg && i_rx_crc_err;

         // a zero written over a set packet ready hands the packet back
         assign sw_clr_prdy = wr_low && !i_wdata[`BIT_PACKET_READY] && prdy_reg;
         // flush runs one cycle after the write and drops one packet only
         assign flush_pop = flush_reg && (occ != 2'h0);
         assign pop       = sw_clr_prdy || flush_pop;

         // handshakes; iso transfers get no ACK or NAK, only STALL while stall request is set
         assign ack_v[g]   = bulk_good;
         assign nak_v[g]   = rx_here && !stall_req_reg && !iso_reg
                             && !i_rx_crc_err && full_v[g];
         assign stall_v[g] = stall_hit;

         // interrupt events: new packet ready or overrun, and each stall
         assign data_ev_v[g]  = (!prdy_reg && (occ != 2'h0) && !pop) || ovr_set;
         assign stall_ev_v[g] = stall_hit;

         assign prdy_v[g]       = prdy_reg;
         assign stall_sent_v[g] = stall_sent_reg;
         assign stall_req_v[g]  = stall_req_reg;
         assign flush_v[g]      = flush_reg;
         assign derr_v[g]       = derr_reg;
         assign ovr_v[g]        = ovr_reg;
         assign dbl_v[g]        = dbl_reg;
         assign iso_v[g]        = iso_reg;

         // packet length queue; the full flag follows the buffering mode
         out_ep_pkt_queue u_queue (
            .i_clock    (i_clock),
            .i_rst_n    (i_rst_n),
            .i_push     (store),
            .i_pop      (pop),
            .i_len      (i_rx_len),
            .i_double   (dbl_reg),
            .o_head_len (head_len[g]),
            .o_occ      (occ),
            .o_full     (full_v[g])
         );

         // packet ready: cleared by pop, raised again while a packet waits
         always @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               prdy_reg <= 1'b0;
            end else if (pop) begin
               prdy_reg <= 1'b0;
            end else if (!prdy_reg && (occ != 2'h0)) begin
               prdy_reg <= 1'b1;
            end
         end

         // flush request; reads one while pending, never partial packets
         always @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               flush_reg <= 1'b0;
            end else if (flush_reg) begin
               flush_reg <= 1'b0;
            end else if (wr_low && i_wdata[`BIT_FLUSH]) begin
               flush_reg <= 1'b1;
            end
         end

         // sticky flags; a set in the clearing cycle wins
         always @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               stall_sent_reg <= 1'b0;
               ovr_reg        <= 1'b0;
               derr_reg       <= 1'b0;
            end else begin
               stall_sent_reg <= stall_hit
                                 || (stall_sent_reg
                                     && !(wr_low && !i_wdata[`BIT_STALL_SENT]));
               ovr_reg        <= ovr_set
                                 || (ovr_reg
                                     && !(wr_low && !i_wdata[`BIT_OVERRUN]));
               derr_reg       <= derr_set || (derr_reg && !sw_clr_prdy);
            end
         end

         // stall request and mode bits are plain software state
         always @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               stall_req_reg <= 1'b0;
               dbl_reg       <= 1'b0;
               iso_reg       <= 1'b0;
            end else begin
               if (wr_low) begin
                  stall_req_reg <= i_wdata[`BIT_STALL_REQUEST];
               end
               if (wr_high) begin
                  dbl_reg <= i_wdata[`BIT_DOUBLE_BUFFER];
                  iso_reg <= i_wdata[`BIT_ISO_MODE];
               end
            end
         end

         // data toggle: software clear beats a same-cycle flip
         always @(posedge i_clock or negedge i_rst_n) begin
            if (!i_rst_n) begin
               toggle_reg <= 1'b0;
            end else if (wr_low && i_wdata[`BIT_TOGGLE_CLEAR]) begin
               toggle_reg <= 1'b0;
            end else if (bulk_good && tog_ok) begin
               toggle_reg <= !toggle_reg;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // interrupt status, enable and clear

   assign irq_event     = {stall_ev_v, 1'b0, data_ev_v, 1'b0};
   // set wins over a clear written in the same cycle
   assign irq_stat_next = irq_event
                          | (irq_stat_reg
                             & ~((i_wr && (i_addr == `OFS_IRQ_CLEAR)) ? i_wdata : 8'h00));

   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat_reg <= `RST_BYTE;
         irq_en_reg   <= `RST_BYTE;
         irq_reg      <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         if (i_wr && (i_addr == `OFS_IRQ_ENABLE)) begin
            irq_en_reg <= i_wdata;
         end
         irq_reg <= |(irq_stat_next & irq_en_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; data stands only in the cycle after the strobe
   always @* begin
      rdata_next = 8'h00;
      if (i_rd) begin
         case (i_addr)
            `OFS_EP_INDEX: begin
               rdata_next = {6'h00, index_reg};
            end
            `OFS_OUT_CTRL_LOW: begin
               if (sel_valid) begin
                  // toggle clear always reads zero
                  rdata_next = {1'b0,
                                stall_sent_v[index_reg],
                                stall_req_v[index_reg],
                                flush_v[index_reg],
                                derr_v[index_reg],
                                ovr_v[index_reg],
                                full_v[index_reg],
                                prdy_v[index_reg]};
               end
            end
            `OFS_OUT_CTRL_HIGH: begin
               if (sel_valid) begin
                  rdata_next = {dbl_v[index_reg], iso_v[index_reg], 6'h00};
               end
            end
            `OFS_RX_COUNT_LOW: begin
               // count is only shown while the packet is ready
               if (sel_valid && prdy_v[index_reg]) begin
                  rdata_next = head_len[index_reg][7:0];
               end
            end
            `OFS_RX_COUNT_HIGH: begin
               if (sel_valid && prdy_v[index_reg]) begin
                  rdata_next = {6'h00, head_len[index_reg][9:8]};
               end
            end
            `OFS_IRQ_STATUS: begin
               rdata_next = irq_stat_reg;
            end
            `OFS_IRQ_ENABLE: begin
               rdata_next = irq_en_reg;
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_reg <= `RST_BYTE;
         ack_reg   <= 1'b0;
         nak_reg   <= 1'b0;
         stall_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         ack_reg   <= |ack_v;
         nak_reg   <= |nak_v;
         stall_reg <= |stall_v;
      end
   end

   assign o_rdata    = rdata_reg;
   assign o_hs_ack   = ack_reg;
   assign o_hs_nak   = nak_reg;
   assign o_hs_stall = stall_reg;
   assign o_irq      = irq_reg;

endmodule // usb_out_ep_ctrl
`default_nettype wire

// [tb/usb_out_ep_ctrl_chk.sv]
// Purpose: port-level checks for the OUT endpoint control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   sees only the top module ports; bound after the module
`timescale 1ns/100ps
`default_nettype none
`include "usb_out_ep_defines.vh"
module usb_out_ep_ctrl_chk (
   // clock and reset
   input wire logic        i_clock,
   input wire logic        i_rst_n,
   // register port
   input wire logic [7:0]  i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [7:0]  o_rdata,
   // receive side and answers
   input wire logic        i_rx_done,
   input wire logic [1:0]  i_rx_ep,
   input wire logic [9:0]  i_rx_len,
   input wire logic        i_rx_toggle,
   input wire logic        i_rx_crc_err,
   input wire logic        o_hs_ack,
   input wire logic        o_hs_nak,
   input wire logic        o_hs_stall,
   input wire logic        o_irq
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////////////////////
   // helpers: interrupt causes; age saturates so a stale cause cannot excuse a rise
   wire       ctl_wr = i_wr && (i_addr == `OFS_OUT_CTRL_LOW);
   wire       clr_wr = i_wr && (i_addr == `OFS_IRQ_CLEAR || i_addr == `OFS_IRQ_ENABLE);
   wire       any_hs = o_hs_ack || o_hs_nak || o_hs_stall;
   logic [2:0] cause_age;
   always @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) cause_age <= 3'h7;
      else if (i_rx_done || ctl_wr || (i_wr && i_addr == `OFS_IRQ_ENABLE)) cause_age <= 3'h0;
      else if (cause_age != 3'h7) cause_age <= cause_age + 3'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // flush write, a quiet cycle, then a control read
   sequence s_flush_wr;
      ctl_wr && i_wdata[`BIT_FLUSH];
   endsequence
   sequence s_ctrl_rd;
      i_rd && (i_addr == `OFS_OUT_CTRL_LOW);
   endsequence
   a_toggle_reads_zero: assert property (s_ctrl_rd |=> !o_rdata[`BIT_TOGGLE_CLEAR])
      else $error("toggle clear bit read as one");
   a_flush_self_clears: assert property (
      s_flush_wr ##1 !i_wr ##1 s_ctrl_rd |=> !o_rdata[`BIT_FLUSH])
      else $error("flush bit still set after flush");
   a_count_high_width: assert property (
      i_rd && i_addr == `OFS_RX_COUNT_HIGH |=> o_rdata[7:2] == 6'h00)
      else $error("count high byte wider than two bits");
   a_hs_has_cause: assert property (
      any_hs |-> $past(i_rx_done) && $past(i_rx_ep) != 2'h0)
      else $error("handshake without a packet");
   a_hs_exclusive: assert property (
      any_hs |-> $onehot({o_hs_ack, o_hs_nak, o_hs_stall}))
      else $error("two handshakes at once");
   a_crc_no_ack: assert property (i_rx_done && i_rx_crc_err |=> !o_hs_ack && !o_hs_nak)
      else $error("errored packet acknowledged");
   a_irq_rise_cause: assert property ($rose(o_irq) |-> cause_age <= 3'h4)
      else $error("interrupt rose without an event");
   a_irq_fall_clear: assert property (
      $fell(o_irq) |-> $past(clr_wr) || $past(clr_wr, 2))
      else $error("interrupt dropped without a clear");
endmodule // usb_out_ep_ctrl_chk
bind usb_out_ep_ctrl usb_out_ep_ctrl_chk i_chk (.i_clock, .i_rst_n, .i_addr, .i_wdata,
   .i_wr, .i_rd, .o_rdata, .i_rx_done, .i_rx_ep, .i_rx_len, .i_rx_toggle, .i_rx_crc_err,
   .o_hs_ack, .o_hs_nak, .o_hs_stall, .o_irq);
`default_nettype wire

// [tb/usb_host_model.sv]
// Purpose: host side model sending OUT data packets
// Assumes: one done pulse per packet, answer read one cycle later
// Notes:   idle data lines toggle so stale values are never trusted
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
   // clock and answers
   input wire logic        i_clock,
   input wire logic        i_hs_ack,
   input wire logic        i_hs_nak,
   input wire logic        i_hs_stall,
   // packet out
   output logic            o_done = 1'b0,
   output logic [1:0]      o_ep   = 2'h0,
   output logic [9:0]      o_len  = 10'h000,
   output logic            o_tog  = 1'b0,
   output logic            o_crc  = 1'b0
);
   logic busy = 1'b0;
   // idle pattern between packets
   always @(posedge i_clock) begin
      if (!busy) begin
         o_len <= ~o_len;
         o_tog <= ~o_tog;
         o_crc <= ~o_crc;
      end
   end
   // host keeps sending OUT packets even to a stalled endpoint
   task send(input [1:0] ep, input [9:0] len, input tog, input crc, output [2:0] hs);
      busy = 1'b1;
      repeat ($urandom_range(2, 0)) @(posedge i_clock);   // prompt or slow host
      @(posedge i_clock);
      o_done <= 1'b1;
      o_ep <= ep;
      o_len <= len;
      o_tog <= tog;
      o_crc <= crc;
      @(posedge i_clock);
      o_done <= 1'b0;
      #1 hs = {i_hs_stall, i_hs_nak, i_hs_ack};
      busy = 1'b0;
   endtask
endmodule // usb_host_model
`default_nettype wire

// [tb/usb_out_endpoint_ctrl_status_tb.sv]
// Purpose: self-checking bench for the OUT endpoint control block
// Assumes: host model drives the receive side
// Notes:   lengths random from a fixed seed, boundary lengths forced
`timescale 1ns/100ps
`default_nettype none
`include "usb_out_ep_defines.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
   $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module usb_out_endpoint_ctrl_status_tb;
   logic       i_clock = 1'b0;
   logic       i_rst_n = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, d;
   logic       wr = 1'b0, rd = 1'b0;
   wire  [7:0] rdata;
   wire        rx_done, rx_tog, rx_crc, ack, nak, stall, irq;
   wire  [1:0] rx_ep;
   wire  [9:0] rx_len;
   logic [2:0] hs;
   logic [9:0] la, lb, lens [1:3];
   int         err_count = 0, tests_run = 0, cyc = 0, ep;
   usb_out_ep_ctrl i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rx_done(rx_done),
      .i_rx_ep(rx_ep), .i_rx_len(rx_len), .i_rx_toggle(rx_tog), .i_rx_crc_err(rx_crc),
      .o_hs_ack(ack), .o_hs_nak(nak), .o_hs_stall(stall), .o_irq(irq));
   usb_host_model h (.i_clock(i_clock), .i_hs_ack(ack), .i_hs_nak(nak),
      .i_hs_stall(stall), .o_done(rx_done), .o_ep(rx_ep), .o_len(rx_len),
      .o_tog(rx_tog), .o_crc(rx_crc));
   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #12.5 i_clock = ~i_clock;
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 8000) begin
         err_count++;
         print_verdict;
      end
   end
   // expected control byte
   function [7:0] cb(input ss, sr, de, ov, fu, rdy);
      cb = {1'b0, ss, sr, 1'b0, de, ov, fu, rdy};
   endfunction
   // register port: strobes one cycle, data in the cycle after a read
   task wr_reg(input [7:0] a, input [7:0] v);
      @(posedge i_clock);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge i_clock);
      wr <= 1'b0;
      wdata <= ~v;
   endtask
   task rd_chk(input [7:0] a, input [7:0] e);
      @(posedge i_clock);
      rd <= 1'b1;
      addr <= a;
      @(posedge i_clock);
      rd <= 1'b0;
      #1 d = rdata;
      `CHK(d, e)
   endtask
   task cnt_chk(input [9:0] e);
      rd_chk(`OFS_RX_COUNT_LOW, e[7:0]);
      rd_chk(`OFS_RX_COUNT_HIGH, {6'h00, e[9:8]});
   endtask
   task print_verdict;
      $display("Checks %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(50));
      repeat (5) @(posedge i_clock);
      i_rst_n <= 1'b1;
      wr_reg(`OFS_IRQ_ENABLE, 8'hEE);
      rd_chk(8'h30, 8'h00);   // unmapped address reads zero
      // bulk per endpoint, boundary lengths on endpoints 1 and 3
      for (ep = 1; ep <= 3; ep++) begin
         // the previous endpoint's last packet left its status bit set
         wr_reg(`OFS_IRQ_CLEAR, 8'hFF);
         la = (ep == 1) ? 10'h000 : (ep == 3) ? 10'h3FF : 10'($urandom_range(1023, 1));
         lb = 10'($urandom_range(1023, 0));
         wr_reg(`OFS_EP_INDEX, ep[7:0]);
         rd_chk(`OFS_OUT_CTRL_LOW, 8'h00);
         h.send(ep[1:0], la, 1'b0, 1'b0, hs);
         `CHK(hs, 3'h1)
         rd_chk(`OFS_OUT_CTRL_LOW, cb(0, 0, 0, 0, 1, 1));
         cnt_chk(la);
         rd_chk(`OFS_IRQ_STATUS, 8'h01 << ep);
         `CHK(irq, 1'b1)
         h.send(ep[1:0], lb, 1'b1, 1'b0, hs);
         `CHK(hs, 3'h2)
         wr_reg(`OFS_OUT_CTRL_LOW, 8'h80);   // toggle back to DATA0, else next is dropped
         wr_reg(`OFS_OUT_CTRL_LOW, 8'h00);
         wr_reg(`OFS_IRQ_CLEAR, 8'hFF);
         rd_chk(`OFS_OUT_CTRL_LOW, 8'h00);
         cnt_chk(10'h000);
         `CHK(irq, 1'b0)
         h.send(ep[1:0], lb, 1'b0, 1'b0, hs);
         rd_chk(`OFS_OUT_CTRL_LOW, cb(0, 0, 0, 0, 1, 1));
         lens[ep] = lb;
      end
      // each endpoint kept its own packet
      for (ep = 1; ep <= 3; ep++) begin
         wr_reg(`OFS_EP_INDEX, ep[7:0]);
         cnt_chk(lens[ep]);
         // endpoint 3 keeps its packet as the first of the double buffer pair
         wr_reg(`OFS_OUT_CTRL_LOW, (ep == 3) ? 8'h81 : 8'h80);
      end
      // double buffered endpoint 3: flush one of two, then pop one of two
      wr_reg(`OFS_OUT_CTRL_HIGH, 8'h80);
      h.send(2'h3, la, 1'b0, 1'b0, hs);
      rd_chk(`OFS_OUT_CTRL_LOW, cb(0, 0, 0, 0, 1, 1));
      // bit0 kept at one so only the flush drops a packet; none was partly read
      wr_reg(`OFS_OUT_CTRL_LOW, 8'h11);
      repeat (3) @(posedge i_clock);
      rd_chk(`OFS_OUT_CTRL_LOW, cb(0, 0, 0, 0, 0, 1));
      cnt_chk(la);
      h.send(2'h3, lb, 1'b1, 1'b0, hs);
      wr_reg(`OFS_OUT_CTRL_LOW, 8'h00);
      rd_chk(`OFS_OUT_CTRL_LOW, cb(0, 0, 0, 0, 0, 1));
      cnt_chk(lb);
      wr_reg(`OFS_OUT_CTRL_LOW, 8'h11);
      rd_chk(`OFS_OUT_CTRL_LOW, 8'h00);
      // stall on endpoint 3, twice, then released
      wr_reg(`OFS_IRQ_CLEAR, 8'hFF);
      wr_reg(`OFS_OUT_CTRL_LOW, 8'h20);
      repeat (2) begin
         h.send(2'h3, la, 1'b0, 1'b0, hs);
         `CHK(hs, 3'h4)
         rd_chk(`OFS_OUT_CTRL_LOW, cb(1, 1, 0, 0, 0, 0));
      end
      rd_chk(`OFS_IRQ_STATUS, 8'h80);
      wr_reg(`OFS_OUT_CTRL_LOW, 8'h80);
      rd_chk(`OFS_OUT_CTRL_LOW, 8'h00);
      h.send(2'h3, la, 1'b0, 1'b0, hs);
      `CHK(hs, 3'h1)
      // isochronous endpoint 1 with the interrupt masked
      wr_reg(`OFS_EP_INDEX, 8'h01);
      wr_reg(`OFS_IRQ_ENABLE, 8'h00);
      wr_reg(`OFS_IRQ_CLEAR, 8'hFF);
      wr_reg(`OFS_OUT_CTRL_HIGH, 8'h40);
      h.send(2'h1, la, 1'b0, 1'b1, hs);
      `CHK(hs, 3'h0)
      rd_chk(`OFS_OUT_CTRL_LOW, cb(0, 0, 1, 0, 1, 1));
      h.send(2'h1, lb, 1'b0, 1'b0, hs);
      rd_chk(`OFS_OUT_CTRL_LOW, cb(0, 0, 1, 1, 1, 1));
      `CHK(irq, 1'b0)   // masked event keeps the line low
      rd_chk(`OFS_IRQ_STATUS, 8'h02);
      wr_reg(`OFS_IRQ_ENABLE, 8'h02);
      repeat (2) @(posedge i_clock);
      `CHK(irq, 1'b1)
      wr_reg(`OFS_OUT_CTRL_LOW, 8'h04);
      rd_chk(`OFS_OUT_CTRL_LOW, cb(0, 0, 0, 1, 0, 0));
      wr_reg(`OFS_OUT_CTRL_LOW, 8'h00);
      wr_reg(`OFS_IRQ_CLEAR, 8'hFF);
      rd_chk(`OFS_OUT_CTRL_LOW, 8'h00);
      `CHK(irq, 1'b0)
      print_verdict;
   end
endmodule // usb_out_endpoint_ctrl_status_tb
`default_nettype wire
